//--- extra_irq_consts.svh
// Constants for the extra interrupt and auxiliary port block
`ifndef EXTRA_IRQ_CONSTS_SVH
`define EXTRA_IRQ_CONSTS_SVH
`define XIC_ADDR 8'hC0
`define AUXP_ADDR 8'hD8
`define XIC_RESET 8'h00
`define AUXP_RESET 8'hFF
`define XIC_EDGE2 0
`define XIC_FLAG2 1
`define XIC_EN2 2
`define XIC_PRIO2 3
`define XIC_EDGE3 4
`define XIC_FLAG3 5
`define XIC_EN3 6
`define XIC_PRIO3 7
`define VEC_EXT0 8'h03
`define VEC_TMR0 8'h0B
`define VEC_EXT1 8'h13
`define VEC_TMR1 8'h1B
`define VEC_SER 8'h23
`define VEC_EXT2 8'h33
`define VEC_EXT3 8'h3B
`define NUM_SRC 7
`define SRC_EXT2 5
`define SRC_EXT3 6
`endif

//--- extra_irq_pkg.sv
// Types shared by the extra interrupt block
package extra_irq_pkg;
    typedef logic [6:0] src_vec_t;
    typedef logic [2:0] src_idx_t;
endpackage

//--- extra_irq_pin_sync.sv
// Two-flop synchroniser and falling-edge detector for one interrupt pin
`timescale 1ns/100ps
`default_nettype none
module extra_irq_pin_sync (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic pin_i,
    output logic level_o,
    output logic fall_o
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    // Reset to high so release does not look like a falling edge
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            prev_q <= 1'b1;
        end
        else
        begin
            meta_q <= pin_i;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level_o = sync_q;
    assign fall_o = prev_q & ~sync_q;
endmodule
`default_nettype wire

//--- extra_irq_port.sv
// Extra interrupt control, auxiliary nibble port and seven-source priority
`timescale 1ns/100ps
`default_nettype none
`include "extra_irq_consts.svh"
module extra_irq_port (
    input wire logic core_clk_i,
    input wire logic srst_i,
    // SFR access from the core, same clock domain
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic sfr_bit_wr_i,
    input wire logic [2:0] sfr_bit_sel_i,
    input wire logic sfr_bit_val_i,
    input wire logic sfr_rmw_i,
    output logic [7:0] sfr_rdata_o,
    output logic sfr_hit_o,
    // Auxiliary port pins
    input wire logic [3:0] aux_pin_i,
    output logic [3:0] aux_pin_o,
    output logic [3:0] aux_pin_oe_o,
    // Standard sources from the core
    input wire logic [4:0] std_req_i,
    input wire logic [4:0] std_prio_high_i,
    input wire logic global_enable_i,
    // Interrupt sequencer
    output logic irq_req_o,
    output logic [7:0] irq_vector_o,
    output logic [2:0] irq_src_o,
    output logic irq_high_o,
    input wire logic irq_ack_i,
    input wire logic irq_reti_i
);
    logic [7:0] xic_q;
    logic [3:0] port_q;
    logic [3:0] pin_sync;
    logic fall2;
    logic fall3;
    logic lvl2;
    logic lvl3;
    logic [3:0] meta_q;
    logic [3:0] psync_q;
    logic hit_xic;
    logic hit_port;
    logic [7:0] xic_wr;
    logic [7:0] port_wr;
    logic ack2;
    logic ack3;
    extra_irq_pkg::src_vec_t req;
    extra_irq_pkg::src_vec_t prio;
    logic [1:0] active_q;
    logic found;
    extra_irq_pkg::src_idx_t win;
    logic win_high;

    // Vector lookup for a source index
    function automatic logic [7:0] vec_of(input extra_irq_pkg::src_idx_t i);
        unique case (i)
            3'd0: vec_of = `VEC_EXT0;
            3'd1: vec_of = `VEC_TMR0;
            3'd2: vec_of = `VEC_EXT1;
            3'd3: vec_of = `VEC_TMR1;
            3'd4: vec_of = `VEC_SER;
            3'd5: vec_of = `VEC_EXT2;
            3'd6: vec_of = `VEC_EXT3;
            default: vec_of = 8'h00;
        endcase
    endfunction

    // Apply a bit write onto a register image
    function automatic logic [7:0] bit_upd(input logic [7:0] cur);
        logic [7:0] r;
        r = cur;
        r[sfr_bit_sel_i] = sfr_bit_val_i;
        bit_upd = r;
    endfunction

    // Interrupt pins 2 and 3 are port bits 2 and 3
    extra_irq_pin_sync u_sync2 (
        .core_clk_i(core_clk_i),
        .srst_i(srst_i),
        .pin_i(aux_pin_i[2]),
        .level_o(lvl2),
        .fall_o(fall2)
    );
    extra_irq_pin_sync u_sync3 (
        .core_clk_i(core_clk_i),
        .srst_i(srst_i),
        .pin_i(aux_pin_i[3]),
        .level_o(lvl3),
        .fall_o(fall3)
    );

    // Port pin read path, all four bits synchronised
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            meta_q <= 4'hF;
            psync_q <= 4'hF;
        end
        else
        begin
            meta_q <= aux_pin_i;
            psync_q <= meta_q;
        end
    end
    assign pin_sync = psync_q;

    assign hit_xic = (sfr_addr_i == `XIC_ADDR);
    assign hit_port = (sfr_addr_i == `AUXP_ADDR);
    assign sfr_hit_o = hit_xic | hit_port;

    // Bit writes allow single-bit set and clear on both registers
    assign xic_wr = sfr_bit_wr_i ? bit_upd(xic_q) : sfr_wdata_i;
    assign port_wr = sfr_bit_wr_i ? bit_upd({4'h0, port_q}) : sfr_wdata_i;

    assign ack2 = irq_ack_i & (win == 3'(`SRC_EXT2));
    assign ack3 = irq_ack_i & (win == 3'(`SRC_EXT3));

    // Control register; hardware flag set wins over software clear
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            xic_q <= `XIC_RESET;
        end
        else
        begin
            if (hit_xic & (sfr_wr_i | sfr_bit_wr_i))
            begin
                xic_q <= xic_wr;
            end
            // Source 2 flag
            if (xic_q[`XIC_EDGE2])
            begin
                if (fall2)
                    xic_q[`XIC_FLAG2] <= 1'b1;
                else if (ack2)
                    xic_q[`XIC_FLAG2] <= 1'b0;
            end
            else
            begin
                xic_q[`XIC_FLAG2] <= ~lvl2;
            end
            // Source 3 flag
            if (xic_q[`XIC_EDGE3])
            begin
                if (fall3)
                    xic_q[`XIC_FLAG3] <= 1'b1;
                else if (ack3)
                    xic_q[`XIC_FLAG3] <= 1'b0;
            end
            else
            begin
                xic_q[`XIC_FLAG3] <= ~lvl3;
            end
        end
    end

    // Port output latch; upper nibble is not implemented
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
            port_q <= 4'(`AUXP_RESET);
        else if (hit_port & (sfr_wr_i | sfr_bit_wr_i))
            port_q <= port_wr[3:0];
    end

    // Quasi-bidirectional: drive only a low, pull-up gives the high
    assign aux_pin_o = 4'h0;
    assign aux_pin_oe_o = ~port_q;

    // Read-modify-write reads the latch, plain reads see the pins
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
            sfr_rdata_o <= 8'h00;
        else if (sfr_rd_i & hit_xic)
            sfr_rdata_o <= xic_q;
        else if (sfr_rd_i & hit_port)
            sfr_rdata_o <= {4'hF, sfr_rmw_i ? port_q : pin_sync};
        else if (sfr_rd_i)
            sfr_rdata_o <= 8'h00;
    end

    // Request and priority vectors for all seven sources
    assign req[4:0] = std_req_i;
    assign req[5] = xic_q[`XIC_FLAG2] & xic_q[`XIC_EN2];
    assign req[6] = xic_q[`XIC_FLAG3] & xic_q[`XIC_EN3];
    assign prio[4:0] = std_prio_high_i;
    assign prio[5] = xic_q[`XIC_PRIO2];
    assign prio[6] = xic_q[`XIC_PRIO3];

    // High level first, then lowest index; active level blocks equal or lower
    always_comb
    begin
        found = 1'b0;
        win = 3'd0;
        win_high = 1'b0;
        for (int i = 0; i < `NUM_SRC; i++)
        begin
            if (!found && req[i] && prio[i] && !active_q[1])
            begin
                found = 1'b1;
                win = i[2:0];
                win_high = 1'b1;
            end
        end
        for (int i = 0; i < `NUM_SRC; i++)
        begin
            if (!found && req[i] && !prio[i] && active_q == 2'b00)
            begin
                found = 1'b1;
                win = i[2:0];
            end
        end
    end

    // Service levels in progress, cleared on return from interrupt
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
            active_q <= 2'b00;
        else if (irq_ack_i & found)
        begin
            if (win_high)
                active_q[1] <= 1'b1;
            else
                active_q[0] <= 1'b1;
        end
        else if (irq_reti_i)
        begin
            if (active_q[1])
                active_q[1] <= 1'b0;
            else
                active_q[0] <= 1'b0;
        end
    end

    assign irq_req_o = found & global_enable_i;
    assign irq_vector_o = vec_of(win);
    assign irq_src_o = win;
    assign irq_high_o = win_high;
endmodule
`default_nettype wire

//--- extra_irq_port_sva.sv
// Port-level assertions for the extra interrupt block
`timescale 1ns/100ps
`default_nettype none
module extra_irq_port_sva (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic sfr_hit_o,
    input wire logic [3:0] aux_pin_o,
    input wire logic [3:0] aux_pin_oe_o,
    input wire logic [4:0] std_req_i,
    input wire logic [4:0] std_prio_high_i,
    input wire logic global_enable_i,
    input wire logic irq_req_o,
    input wire logic [7:0] irq_vector_o,
    input wire logic [2:0] irq_src_o,
    input wire logic irq_high_o
);
default clocking @(posedge core_clk_i); endclocking
default disable iff (srst_i);
// Same-level standard requests polled ahead of the winner
logic [4:0] ahead;
assign ahead = std_req_i & (irq_high_o ? std_prio_high_i : ~std_prio_high_i)
    & 5'((8'h01 << irq_src_o) - 8'h01);
// Extra sources skip the unused slot after the serial port
logic [2:0] vec_slot;
logic [7:0] vec_exp;
logic [4:0] high_wait;
assign vec_slot = irq_src_o + {2'h0, irq_src_o > 3'h4};
assign vec_exp = 8'h03 + {2'h0, vec_slot, 3'h0};
assign high_wait = std_req_i & std_prio_high_i;
sequence s_port_wr;
    sfr_wr_i && sfr_addr_i == 8'hD8;
endsequence
sequence s_bad_rd;
    sfr_rd_i && !sfr_hit_o;
endsequence
a_port_drive: assert property (s_port_wr |=> aux_pin_oe_o == ~$past(sfr_wdata_i[3:0]))
    else $error("port enable wrong");
a_pin_sink: assert property (aux_pin_o == 4'h0)
    else $error("pin drives high");
a_vector_map: assert property (irq_req_o |-> irq_vector_o == vec_exp)
    else $error("vector wrong");
a_global_gate: assert property (!global_enable_i |-> !irq_req_o)
    else $error("request not gated");
a_high_first: assert property (irq_req_o && !irq_high_o |-> high_wait == 5'h00)
    else $error("low beat high");
a_poll_order: assert property (irq_req_o |-> ahead == 5'h00)
    else $error("polling order wrong");
a_unmapped_rd: assert property (s_bad_rd |=> sfr_rdata_o == 8'h00)
    else $error("unmapped read data");
a_rdata_hold: assert property (!sfr_rd_i |=> $stable(sfr_rdata_o))
    else $error("read data moved");
a_hit_decode: assert property (sfr_hit_o == (sfr_addr_i == 8'hC0 || sfr_addr_i == 8'hD8))
    else $error("address decode wrong");
a_release_idle: assert property ($fell(srst_i) |-> aux_pin_oe_o == 4'h0)
    else $error("pins driven after reset");
endmodule
bind extra_irq_port extra_irq_port_sva sva_u (.*);
`default_nettype wire

//--- pin_seq_model.sv
// Pulled-up pin wiring and interrupt sequencer model
`timescale 1ns/100ps
`default_nettype none
module pin_seq_model (
    input wire logic core_clk_i,
    input wire logic [3:0] pull_low_i,
    input wire logic [3:0] drv_i,
    input wire logic [3:0] oe_i,
    input wire logic req_i,
    input wire logic ack_en_i,
    output logic [3:0] pin_o,
    output logic ack_o
);
// Pull-up wins unless the port or the outside sinks the wire
assign pin_o = ~(oe_i & ~drv_i) & ~pull_low_i;
// One vector pulse per request, only when the bench allows it
always_ff @(posedge core_clk_i)
    ack_o <= ack_en_i & req_i & ~ack_o;
endmodule
`default_nettype wire

//--- test_extra_irq_port.sv
// Directed test of the extra interrupt block
`timescale 1ns/100ps
`default_nettype none
module test_extra_irq_port;
logic clk = 1'b0, rst = 1'b1, wr = 0, rd = 0, bw = 0, bv = 0, rmw = 0, ge = 0, rt = 0, aen = 0;
logic [7:0] a = 8'h00, d = 8'h00, q, vec;
logic [4:0] sr = 5'h00, sp = 5'h00;
logic [3:0] pl = 4'h0, po, oe, pins;
logic [2:0] bs = 3'h0, src;
logic hit, req, hi, ack;
int error_cnt = 0, num_checks = 0;
always #5 clk = ~clk;
extra_irq_port dut_u (.core_clk_i(clk), .srst_i(rst), .sfr_addr_i(a), .sfr_wdata_i(d),
    .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_bit_wr_i(bw), .sfr_bit_sel_i(bs),
    .sfr_bit_val_i(bv), .sfr_rmw_i(rmw), .sfr_rdata_o(q), .sfr_hit_o(hit),
    .aux_pin_i(pins), .aux_pin_o(po), .aux_pin_oe_o(oe), .std_req_i(sr),
    .std_prio_high_i(sp), .global_enable_i(ge), .irq_req_o(req), .irq_vector_o(vec),
    .irq_src_o(src), .irq_high_o(hi), .irq_ack_i(ack), .irq_reti_i(rt));
pin_seq_model seq_u (.core_clk_i(clk), .pull_low_i(pl), .drv_i(po), .oe_i(oe),
    .req_i(req), .ack_en_i(aen), .pin_o(pins), .ack_o(ack));
task automatic close_out();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
        $display("Simulation passed");
    else
        $display("Simulation failed");
    $finish;
endtask
task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
        error_cnt++;
        $display("MISMATCH %s exp %h got %h", n, e, g);
    end
endtask
// Access kinds {bit, rmw, read, write}; bit writes carry select in v[6:4], value in v[0]
task automatic op(input logic [3:0] k, input logic [7:0] ad, input logic [7:0] v);
    @(negedge clk);
    {bw, rmw, rd, wr} = k;
    a = ad;
    d = v;
    bs = v[6:4];
    bv = v[0];
    @(negedge clk);
    {bw, rmw, rd, wr} = 4'h0;
endtask
task automatic rdc(input string n, input logic m, input logic [7:0] ad, input logic [7:0] e);
    op({1'b0, m, 2'h2}, ad, 8'h00);
    chk(n, e, q);
endtask
// Bounded wait on the request line; running out ends the run
task automatic wait_req(input logic v);
    int n;
    n = 0;
    while (req !== v && n < 20)
    begin
        @(negedge clk);
        n++;
    end
    if (req !== v)
    begin
        error_cnt++;
        close_out();
    end
endtask
initial
begin
    repeat (2) @(negedge clk);
    rst = 0;
    rdc("ctrl", 0, 8'hC0, 8'h00);
    chk("hitc", 8'h01, {7'h0, hit});
    rdc("latch", 1, 8'hD8, 8'hFF);
    op(4'h1, 8'hD8, 8'h0A);
    chk("oe", 8'h05, {4'h0, oe});
    repeat (3) @(negedge clk);
    rdc("pins", 0, 8'hD8, 8'hFA);
    op(4'h1, 8'hD8, 8'hFA | 8'h01);
    op(4'h1, 8'hD8, 8'hFB & 8'hFD);
    rdc("rmw", 1, 8'hD8, 8'hF9);
    op(4'h8, 8'hD8, 8'h30);
    rdc("bitclr", 1, 8'hD8, 8'hF1);
    // Release pins 2 and 3 so the level-mode flags settle clear
    op(4'h1, 8'hD8, 8'h0F);
    op(4'h1, 8'h55, 8'h12);
    rdc("unmap", 0, 8'h55, 8'h00);
    chk("hitu", 8'h00, {7'h0, hit});
    rdc("ignore", 1, 8'hD8, 8'hFF);
    op(4'h8, 8'hC0, 8'h21);
    rdc("setb", 0, 8'hC0, 8'h04);
    op(4'h1, 8'hC0, 8'hDD);
    rdc("layout", 0, 8'hC0, 8'hDD);
    op(4'h1, 8'hC0, 8'h05);
    ge = 1;
    pl = 4'h4;
    wait_req(1);
    chk("vec2", 8'h33, vec);
    chk("src2", 8'h05, {5'h0, src});
    chk("lvl2", 8'h00, {7'h0, hi});
    rdc("flag2", 0, 8'hC0, 8'h07);
    aen = 1;
    wait_req(0);
    aen = 0;
    rdc("svc2", 0, 8'hC0, 8'h05);
    pl = 4'h0;
    // One return pulse only
    rt = 1;
    @(negedge clk);
    rt = 0;
    op(4'h1, 8'hC0, 8'h01);
    pl = 4'h4;
    repeat (6) @(negedge clk);
    chk("masked", 8'h00, {7'h0, req});
    rdc("flagm", 0, 8'hC0, 8'h03);
    pl = 4'h0;
    op(4'h1, 8'hC0, 8'hC0);
    pl = 4'h8;
    wait_req(1);
    chk("vec3", 8'h3B, vec);
    chk("src3", 8'h06, {5'h0, src});
    chk("lvl3", 8'h01, {7'h0, hi});
    pl = 4'h0;
    wait_req(0);
    op(4'h1, 8'hC0, 8'h00);
    // Each change lands on a falling edge, clear of the sampling edge
    for (int i = 0; i < 5; i++)
    begin
        @(negedge clk);
        sr = 5'h01 << i;
        #1 chk("std", 8'h03 + 8'(i * 8), vec);
    end
    @(negedge clk);
    sr = 5'h1F;
    #1 chk("poll", 8'h03, vec);
    @(negedge clk);
    sp = 5'h10;
    #1 chk("high", 8'h23, vec);
    @(negedge clk);
    ge = 0;
    #1 chk("gate", 8'h00, {7'h0, req});
    close_out();
end
endmodule
`default_nettype wire
